// ---- logic/cani_cfg.svh ----
`ifndef CANI_CFG_SVH
`define CANI_CFG_SVH
// Register byte offsets
`define CANI_MODE_OFS 12'h000
`define CANI_IER_OFS 12'h004
`define CANI_IDR_OFS 12'h008
`define CANI_IMR_OFS 12'h00C
`define CANI_SR_OFS 12'h010
`define CANI_BR_OFS 12'h014
`define CANI_TIM_OFS 12'h018
`define CANI_STAMP_OFS 12'h01C
`define CANI_ECR_OFS 12'h020
`define CANI_MB_BASE 12'h200
`define CANI_MB_MMR 5'h00
`define CANI_MB_MAM 5'h04
`define CANI_MB_MID 5'h08
`define CANI_MB_MSR 5'h10
`define CANI_MB_MDL 5'h14
`define CANI_MB_MDH 5'h18
`define CANI_MB_MCR 5'h1C
// Mode register fields
`define CANI_MODE_EN 0
`define CANI_MODE_LISTEN 1
`define CANI_MODE_LPM 2
// Status and mask positions above the eight mailbox bits
`define CANI_SR_ERRA 16
`define CANI_SR_WARN 17
`define CANI_SR_ERRP 18
`define CANI_SR_BOFF 19
`define CANI_SR_SLEEP 20
`define CANI_SR_WAKE 21
`define CANI_SR_TOVF 22
`define CANI_SR_TSTP 23
`define CANI_SR_EFLG 24
// Mailbox field positions
`define CANI_MMR_OT_LSB 24
`define CANI_MSR_DLC_LSB 16
`define CANI_MSR_RDY 23
`define CANI_MSR_LOST 24
`define CANI_MCR_XFER 23
// Counts and limits
`define CANI_MB_NUM 8
`define CANI_SYNC_BITS 4'hB
`define CANI_TQ_PER_BIT 8'h10
`define CANI_WARN_LIM 9'h060
`define CANI_PASSIVE_LIM 9'h080
`define CANI_BOFF_LIM 9'h100
`define CANI_TEC_STEP 9'h008
`define CANI_REC_MAX 9'h0FF
`define CANI_IMR_RESET 32'h0000_0000
`define CANI_BR_RESET 32'h0000_0000
`endif

// ---- logic/cani_pkg.sv ----
package cani_pkg;
	typedef enum logic [1:0]
	{
		ST_OFF = 2'b00,
		ST_SYNC = 2'b01,
		ST_ACTIVE = 2'b10,
		ST_SLEEP = 2'b11
	} cani_state_type;

	typedef enum logic [2:0]
	{
		OT_DISABLED = 3'b000,
		OT_RX = 3'b001,
		OT_RX_OVR = 3'b010
	} cani_object_type;

	typedef struct packed
	{
		logic valid;
		logic [28:0] id;
		logic [3:0] dlc;
		logic [31:0] data_high;
		logic [31:0] data_low;
	} cani_rx_msg_type;

	typedef struct packed
	{
		logic tx_err;
		logic rx_err;
		logic tx_ok;
		logic rx_ok;
		logic [4:0] flags;
		logic frame_start;
		logic frame_end;
		logic tx_idle;
	} cani_proto_evt_type;
endpackage : cani_pkg

// ---- logic/cani_ctrl.sv ----
// How it works
// - Stays off the bus until enabled
// - Enable resets engine, counters, error flags
// - Eleven recessive bits synchronise the controller
// - Synced flag sets; both flags zero after reset
// - Autobaud freezes counters; mailboxes still receive
// - Mailbox and system interrupt classes
// - Enable/disable writes set masks; reset masks all
// - Mailbox source raised when data ready
// - Bus-off, passive, active status sources
// - Warning when active and counter above 96
// - Wake after sync; sleep after pending sent
// - Timer rollover raises overflow source
// - Frame start/end captures timer, raises stamp
// - Status read clears overflow, stamp and error flags
// - Receive keeps first, overwrite keeps latest
// - Enabling receive clears ready until message
// - Transfer command releases data, clears ready
// - Receive mode discards extra, flags loss
// - Overwrite mode replaces data, flags loss
// - Eight independent mailboxes
`include "cani_cfg.svh"

module cani_ctrl
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus pin and protocol engine
	input wire logic can_rx,
	input wire cani_pkg::cani_rx_msg_type rx_msg,
	input wire cani_pkg::cani_proto_evt_type proto_evt,
	output logic proto_reset,
	output logic bus_active,
	output logic listen_only,
	// Interrupt line
	output logic irq
);
	logic [31:0] mode_control_reg;
	logic [31:0] bit_timing_reg;
	logic [31:0] irq_mask_reg;
	logic [31:0] stamp_capture_reg;
	logic [15:0] timer;
	logic [8:0] tec;
	logic [8:0] rec;
	logic [4:0] err_flags;
	logic timer_ovf;
	logic stamp_flag;
	logic bus_synced_flag;
	logic sleep_flag;
	cani_pkg::cani_state_type state;
	cani_pkg::cani_state_type next_state;
	logic rx_meta;
	logic rx_pin;
	logic [7:0] tq_cnt;
	logic [6:0] brp_cnt;
	logic bit_tick;
	logic [3:0] rec_run;
	logic enable_q;
	logic enable_rise;
	logic [2:0] mb_type [0:7];
	logic [28:0] mb_id [0:7];
	logic [28:0] mb_mask [0:7];
	logic [31:0] mb_data_low [0:7];
	logic [31:0] mb_data_high [0:7];
	logic [3:0] mb_dlc [0:7];
	logic [7:0] mailbox_ready_flag;
	logic [7:0] message_lost_flag;
	logic [7:0] mb_store;
	logic [7:0] mb_lose;
	logic [31:0] status;
	logic erra;
	logic errp;
	logic boff;
	logic warn;
	logic wr_acc;
	logic rd_acc;
	logic setup;
	logic mb_hit;
	logic [2:0] mb_sel;
	logic [4:0] mb_ofs;
	logic [31:0] next_rdata;
	logic next_err;

	function automatic logic cani_match(input logic [28:0] id, input logic [28:0] ref_id,
		input logic [28:0] mask);
		cani_match = ((id ^ ref_id) & mask) == 29'h0;
	endfunction : cani_match

	function automatic logic cani_is_rx(input logic [2:0] ot);
		cani_is_rx = (ot == cani_pkg::OT_RX) || (ot == cani_pkg::OT_RX_OVR);
	endfunction : cani_is_rx

	// APB decode; the slave never inserts wait states
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign mb_hit = paddr >= `CANI_MB_BASE
		&& paddr < (`CANI_MB_BASE + 12'(`CANI_MB_NUM * 32));
	assign mb_sel = paddr[7:5];
	assign mb_ofs = paddr[4:0];

	// Pin synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_meta <= 1'b1;
			rx_pin <= 1'b1;
		end
		else
		begin
			rx_meta <= can_rx;
			rx_pin <= rx_meta;
		end
	end

	// Bit clock from the prescaler field; one sample per bit time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tq_cnt <= 8'h00;
			brp_cnt <= 7'h00;
		end
		else if (state == cani_pkg::ST_OFF)
		begin
			tq_cnt <= 8'h00;
			brp_cnt <= 7'h00;
		end
		else if (brp_cnt != bit_timing_reg[6:0])
			brp_cnt <= brp_cnt + 7'h01;
		else
		begin
			brp_cnt <= 7'h00;
			tq_cnt <= (tq_cnt == `CANI_TQ_PER_BIT - 8'h01) ? 8'h00 : tq_cnt + 8'h01;
		end
	end
	assign bit_tick = (brp_cnt == bit_timing_reg[6:0])
		&& (tq_cnt == `CANI_TQ_PER_BIT - 8'h01);

	// Controller enable edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable_q <= 1'b0;
		else
			enable_q <= mode_control_reg[`CANI_MODE_EN];
	end
	assign enable_rise = mode_control_reg[`CANI_MODE_EN] && !enable_q;
	assign proto_reset = enable_rise;

	// Recessive run counter used for bus synchronisation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rec_run <= 4'h0;
		else if (state != cani_pkg::ST_SYNC)
			rec_run <= 4'h0;
		else if (bit_tick)
			rec_run <= rx_pin ? rec_run + 4'h1 : 4'h0;
	end

	// Controller state
	always_comb
	begin
		next_state = state;
		case (state)
			cani_pkg::ST_OFF:
				if (enable_rise)
					next_state = cani_pkg::ST_SYNC;
			cani_pkg::ST_SYNC:
				if (bit_tick && rx_pin && rec_run == `CANI_SYNC_BITS - 4'h1)
					next_state = cani_pkg::ST_ACTIVE;
			cani_pkg::ST_ACTIVE:
				if (mode_control_reg[`CANI_MODE_LPM] && proto_evt.tx_idle)
					next_state = cani_pkg::ST_SLEEP;
			cani_pkg::ST_SLEEP:
				if (!mode_control_reg[`CANI_MODE_LPM])
					next_state = cani_pkg::ST_SYNC;
			default:
				next_state = cani_pkg::ST_OFF;
		endcase
		if (!mode_control_reg[`CANI_MODE_EN])
			next_state = cani_pkg::ST_OFF;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= cani_pkg::ST_OFF;
		else
			state <= next_state;
	end
	assign bus_active = state == cani_pkg::ST_ACTIVE;
	assign listen_only = mode_control_reg[`CANI_MODE_LISTEN];

	// Wake and sleep flags are exclusive once the first sync is done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_synced_flag <= 1'b0;
			sleep_flag <= 1'b0;
		end
		else if (state != cani_pkg::ST_ACTIVE && next_state == cani_pkg::ST_ACTIVE)
		begin
			bus_synced_flag <= 1'b1;
			sleep_flag <= 1'b0;
		end
		else if (state == cani_pkg::ST_ACTIVE && next_state == cani_pkg::ST_SLEEP)
		begin
			bus_synced_flag <= 1'b0;
			sleep_flag <= 1'b1;
		end
	end

	// Error counters; frozen in autobaud and while asleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tec <= 9'h000;
			rec <= 9'h000;
		end
		else if (enable_rise)
		begin
			tec <= 9'h000;
			rec <= 9'h000;
		end
		else if (state == cani_pkg::ST_ACTIVE && !mode_control_reg[`CANI_MODE_LISTEN])
		begin
			if (proto_evt.tx_err && !boff)
				tec <= (tec > `CANI_BOFF_LIM - `CANI_TEC_STEP) ? `CANI_BOFF_LIM
					: tec + `CANI_TEC_STEP;
			else if (proto_evt.tx_ok && tec != 9'h000 && !boff)
				tec <= tec - 9'h001;
			if (proto_evt.rx_err && rec != `CANI_REC_MAX)
				rec <= rec + 9'h001;
			else if (proto_evt.rx_ok && rec != 9'h000)
				rec <= rec - 9'h001;
		end
	end

	// Fault confinement status, live and not latched
	assign boff = tec >= `CANI_BOFF_LIM;
	assign errp = tec >= `CANI_PASSIVE_LIM || rec >= `CANI_PASSIVE_LIM;
	assign erra = !errp && !boff;
	assign warn = erra && (tec > `CANI_WARN_LIM || rec > `CANI_WARN_LIM);

	// Error flags: a new error in the clearing cycle still lands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_flags <= 5'h00;
		else if (enable_rise)
			err_flags <= 5'h00;
		else if (rd_acc && paddr == `CANI_SR_OFS)
			err_flags <= proto_evt.flags;
		else
			err_flags <= err_flags | proto_evt.flags;
	end

	// Free-running timer, overflow and timestamp
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer <= 16'h0000;
		else if (state == cani_pkg::ST_OFF)
			timer <= 16'h0000;
		else if (bit_tick)
			timer <= timer + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_ovf <= 1'b0;
			stamp_flag <= 1'b0;
			stamp_capture_reg <= 32'h0000_0000;
		end
		else
		begin
			if (bit_tick && timer == 16'hFFFF && state != cani_pkg::ST_OFF)
				timer_ovf <= 1'b1;
			else if (rd_acc && paddr == `CANI_SR_OFS)
				timer_ovf <= 1'b0;
			if (proto_evt.frame_start || proto_evt.frame_end)
			begin
				stamp_capture_reg <= {16'h0000, timer};
				stamp_flag <= 1'b1;
			end
			else if (rd_acc && paddr == `CANI_SR_OFS)
				stamp_flag <= 1'b0;
		end
	end

	// Mailbox acceptance: lowest free match wins so chained boxes fill in order
	always_comb
	begin
		mb_store = 8'h00;
		mb_lose = 8'h00;
		if (rx_msg.valid && state == cani_pkg::ST_ACTIVE)
		begin
			for (int i = `CANI_MB_NUM - 1; i >= 0; i--)
				if (cani_is_rx(mb_type[i]) && cani_match(rx_msg.id, mb_id[i], mb_mask[i])
					&& (!mailbox_ready_flag[i] || mb_type[i] == cani_pkg::OT_RX_OVR))
				begin
					mb_store = 8'h00;
					mb_store[i] = 1'b1;
				end
			if (mb_store == 8'h00)
				for (int i = `CANI_MB_NUM - 1; i >= 0; i--)
					if (cani_is_rx(mb_type[i]) && cani_match(rx_msg.id, mb_id[i], mb_mask[i]))
					begin
						mb_lose = 8'h00;
						mb_lose[i] = 1'b1;
					end
		end
	end

	// Eight mailboxes, each with its own mode and flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mailbox_ready_flag <= 8'h00;
			message_lost_flag <= 8'h00;
			for (int i = 0; i < `CANI_MB_NUM; i++)
			begin
				mb_type[i] <= 3'b000;
				mb_id[i] <= 29'h0;
				mb_mask[i] <= 29'h0;
				mb_data_low[i] <= 32'h0000_0000;
				mb_data_high[i] <= 32'h0000_0000;
				mb_dlc[i] <= 4'h0;
			end
		end
		else
		begin
			for (int i = 0; i < `CANI_MB_NUM; i++)
			begin
				if (wr_acc && mb_hit && mb_sel == 3'(i))
				begin
					if (mb_ofs == `CANI_MB_MMR)
						mb_type[i] <= pwdata[`CANI_MMR_OT_LSB +: 3];
					if (mb_ofs == `CANI_MB_MAM)
						mb_mask[i] <= pwdata[28:0];
					if (mb_ofs == `CANI_MB_MID)
						mb_id[i] <= pwdata[28:0];
				end
				if (mb_store[i])
				begin
					mb_data_low[i] <= rx_msg.data_low;
					mb_data_high[i] <= rx_msg.data_high;
					mb_dlc[i] <= rx_msg.dlc;
					mailbox_ready_flag[i] <= 1'b1;
				end
				else if (wr_acc && mb_hit && mb_sel == 3'(i)
					&& ((mb_ofs == `CANI_MB_MMR) || (mb_ofs == `CANI_MB_MCR
					&& pwdata[`CANI_MCR_XFER])))
					mailbox_ready_flag[i] <= 1'b0;
				if (mb_lose[i] || (mb_store[i] && mailbox_ready_flag[i]))
					message_lost_flag[i] <= 1'b1;
				else if ((rd_acc && mb_hit && mb_sel == 3'(i) && mb_ofs == `CANI_MB_MSR)
					|| (wr_acc && mb_hit && mb_sel == 3'(i) && mb_ofs == `CANI_MB_MMR))
					message_lost_flag[i] <= 1'b0;
			end
		end
	end

	// Global registers written by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_control_reg <= 32'h0000_0000;
			bit_timing_reg <= `CANI_BR_RESET;
			irq_mask_reg <= `CANI_IMR_RESET;
		end
		else if (wr_acc)
		begin
			if (paddr == `CANI_MODE_OFS)
				mode_control_reg <= {29'h0, pwdata[2:0]};
			if (paddr == `CANI_BR_OFS)
				bit_timing_reg <= pwdata;
			if (paddr == `CANI_IER_OFS)
				irq_mask_reg <= irq_mask_reg | (pwdata & 32'h00FF_00FF);
			if (paddr == `CANI_IDR_OFS)
				irq_mask_reg <= irq_mask_reg & ~pwdata;
		end
	end

	// Status word: mailbox sources low, system sources high
	always_comb
	begin
		status = 32'h0000_0000;
		status[7:0] = mailbox_ready_flag;
		status[`CANI_SR_ERRA] = erra;
		status[`CANI_SR_WARN] = warn;
		status[`CANI_SR_ERRP] = errp;
		status[`CANI_SR_BOFF] = boff;
		status[`CANI_SR_SLEEP] = sleep_flag;
		status[`CANI_SR_WAKE] = bus_synced_flag;
		status[`CANI_SR_TOVF] = timer_ovf;
		status[`CANI_SR_TSTP] = stamp_flag;
		status[`CANI_SR_EFLG +: 5] = err_flags;
	end
	assign irq = |(status & irq_mask_reg);

	// Read mux, captured in the setup cycle so data is a flop output
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (mb_hit)
			case (mb_ofs)
				`CANI_MB_MMR: next_rdata[`CANI_MMR_OT_LSB +: 3] = mb_type[mb_sel];
				`CANI_MB_MAM: next_rdata[28:0] = mb_mask[mb_sel];
				`CANI_MB_MID: next_rdata[28:0] = mb_id[mb_sel];
				`CANI_MB_MSR:
				begin
					next_rdata[`CANI_MSR_DLC_LSB +: 4] = mb_dlc[mb_sel];
					next_rdata[`CANI_MSR_RDY] = mailbox_ready_flag[mb_sel];
					next_rdata[`CANI_MSR_LOST] = message_lost_flag[mb_sel];
				end
				`CANI_MB_MDL: next_rdata = mb_data_low[mb_sel];
				`CANI_MB_MDH: next_rdata = mb_data_high[mb_sel];
				`CANI_MB_MCR: next_rdata = 32'h0000_0000;
				default: next_err = 1'b1;
			endcase
		else
			case (paddr)
				`CANI_MODE_OFS: next_rdata = mode_control_reg;
				`CANI_IER_OFS: next_rdata = 32'h0000_0000;
				`CANI_IDR_OFS: next_rdata = 32'h0000_0000;
				`CANI_IMR_OFS: next_rdata = irq_mask_reg;
				`CANI_SR_OFS: next_rdata = status;
				`CANI_BR_OFS: next_rdata = bit_timing_reg;
				`CANI_TIM_OFS: next_rdata = {16'h0000, timer};
				`CANI_STAMP_OFS: next_rdata = stamp_capture_reg;
				`CANI_ECR_OFS: next_rdata = {7'h00, tec, 7'h00, rec};
				default: next_err = 1'b1;
			endcase
	end

	// Status read in the access cycle returns the value seen at setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= next_err;
		end
		else if (!psel)
			pslverr <= 1'b0;
	end
endmodule : cani_ctrl

// ---- tb/cani_ctrl_sva.sv ----
`include "cani_cfg.svh"

module cani_ctrl_sva
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Bus side
	input wire logic can_rx,
	input wire logic proto_reset,
	input wire logic bus_active,
	input wire logic listen_only,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr;
	logic en_q;
	logic [23:0] imr;
	logic [7:0] run;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_q <= 1'b0;
		else if (wr && paddr == `CANI_MODE_OFS)
			en_q <= pwdata[0];

	// Reserved bits 15:8 never hold a mask
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			imr <= 24'h000000;
		else if (wr && paddr == `CANI_IER_OFS)
			imr <= (imr | pwdata[23:0]) & 24'hFF00FF;
		else if (wr && paddr == `CANI_IDR_OFS)
			imr <= imr & ~pwdata[23:0];

	// Saturates, so a long idle bus cannot wrap to a short run
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			run <= 8'h00;
		else if (!can_rx)
			run <= 8'h00;
		else if (run != 8'hFF)
			run <= run + 8'h01;

	a_enable_pulse: assert property (
		proto_reset |=> !proto_reset) else $error("enable pulse too long");
	a_enable_cause: assert property (
		proto_reset |-> $past(wr && paddr == `CANI_MODE_OFS && pwdata[0]))
		else $error("engine reset without enable write");
	a_sync_wait: assert property (
		proto_reset |=> !bus_active [*8]) else $error("active right after enable");
	a_recessive_run: assert property (
		$rose(bus_active) |-> run >= 8'hA0) else $error("synced without idle run");
	a_off_quiet: assert property (
		!en_q && !$past(en_q) |-> !bus_active) else $error("active while disabled");
	a_listen_mode: assert property (
		wr && paddr == `CANI_MODE_OFS |=> listen_only == $past(pwdata[1]))
		else $error("autobaud level wrong");
	a_mask_read: assert property (
		psel && !penable && !pwrite && paddr == `CANI_IMR_OFS |=> prdata[23:0] == imr)
		else $error("mask readback wrong");
	a_irq_masked: assert property (
		imr == 24'h000000 |-> !irq) else $error("irq with all masked");
endmodule : cani_ctrl_sva

bind cani_ctrl cani_ctrl_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .can_rx, .proto_reset, .bus_active, .listen_only, .irq);

// ---- tb/cani_far_node.sv ----
module cani_far_node
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus side
	output logic can_rx,
	output cani_pkg::cani_rx_msg_type rx_msg,
	output cani_pkg::cani_proto_evt_type proto_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam cani_pkg::cani_proto_evt_type IDLE = 12'h001;

	initial
	begin
		can_rx = 1'b1;
		rx_msg = '0;
		proto_evt = IDLE;
	end

	// Traffic on the bus, then recessive idle
	task automatic hold_dominant(input int n);
		@(posedge pclk);
		can_rx <= 1'b0;
		repeat (n) @(posedge pclk);
		can_rx <= 1'b1;
	endtask : hold_dominant

	// Fields are scrambled once the frame is gone, so stale data cannot pass
	task automatic send(input logic [28:0] id, input logic [31:0] dh, input logic [31:0] dl);
		@(posedge pclk);
		rx_msg <= {1'b1, id, 4'h8, dh, dl};
		@(posedge pclk);
		rx_msg <= {1'b0, ~id, 4'h7, ~dh, ~dl};
	endtask : send

	task automatic pulse(input cani_pkg::cani_proto_evt_type e);
		@(posedge pclk);
		proto_evt <= e;
		@(posedge pclk);
		proto_evt <= IDLE;
	endtask : pulse
endmodule : cani_far_node

// ---- tb/tb.sv ----
`include "cani_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, qerr;
	logic can_rx, proto_reset, bus_active, listen_only, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, d0, d1, lfsr;
	cani_pkg::cani_rx_msg_type rx_msg;
	cani_pkg::cani_proto_evt_type proto_evt, e;
	int errors, compares, n;

	cani_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .can_rx, .rx_msg, .proto_evt, .proto_reset, .bus_active,
		.listen_only, .irq);
	cani_far_node u_far (.pclk, .presetn, .can_rx, .rx_msg, .proto_evt);

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	function automatic logic [11:0] mb(input int k, input logic [4:0] o);
		return `CANI_MB_BASE + 12'(k) * 12'h020 + {7'h00, o};
	endfunction : mb

	function automatic logic [31:0] kept(input logic ovr, input logic [31:0] a, input logic [31:0] b);
		return ovr ? b : a;
	endfunction : kept

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		qerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic errs(input int k);
		e = 12'h001;
		e.rx_err = 1'b1;
		repeat (k) u_far.pulse(e);
	endtask : errs

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#160000;
		errors++;
		$display("mismatch at %0t: run hung", $time);
		report_and_stop();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lfsr = 32'hB7FD7C91;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CANI_IMR_OFS, 32'h0);
		check(q, `CANI_IMR_RESET, "mask reset");
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[21:20]), 32'h0, "wake sleep reset");
		apb(1'b0, 12'h100, 32'h0);
		check({31'h0, qerr}, 32'h1, "unmapped error");
		check(q, 32'h0, "unmapped data");
		$display("reset test done");

		apb(1'b1, `CANI_BR_OFS, 32'h0);
		apb(1'b1, `CANI_MODE_OFS, 32'h1);
		u_far.hold_dominant(40);
		n = 41;
		while (bus_active !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		check(32'(n >= 200 && n <= 260), 32'h1, "sync time");
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[21]), 32'h1, "synced flag");
		check(32'(q[16]), 32'h1, "error active");
		apb(1'b0, `CANI_ECR_OFS, 32'h0);
		check(q, 32'h0, "counters cleared");
		apb(1'b1, `CANI_IER_OFS, 32'h000000FF);
		apb(1'b1, `CANI_IDR_OFS, 32'h00000003);
		apb(1'b0, `CANI_IMR_OFS, 32'h0);
		check(q, 32'h000000FC, "mask set clear");
		apb(1'b1, `CANI_IER_OFS, 32'h00000003);
		$display("enable test done");

		for (n = 0; n < 8; n++)
		begin
			apb(1'b1, mb(n, `CANI_MB_MID), 32'(n + 256));
			apb(1'b1, mb(n, `CANI_MB_MAM), 32'h1FFFFFFF);
			apb(1'b1, mb(n, `CANI_MB_MMR),
				32'(n[0] ? cani_pkg::OT_RX_OVR : cani_pkg::OT_RX) << `CANI_MMR_OT_LSB);
			apb(1'b0, mb(n, `CANI_MB_MSR), 32'h0);
			check(32'(q[23]), 32'h0, "ready after mode");
			lfsr = next_rand(lfsr);
			d0 = lfsr;
			lfsr = next_rand(lfsr);
			d1 = lfsr;
			u_far.send(29'(n + 256), d0, ~d0);
			apb(1'b0, `CANI_SR_OFS, 32'h0);
			check(32'(q[n]), 32'h1, "mailbox source");
			check(32'(irq), 32'h1, "mailbox irq");
			u_far.send(29'(n + 256), d1, ~d1);
			apb(1'b0, mb(n, `CANI_MB_MSR), 32'h0);
			check(32'(q[24:23]), 32'h3, "lost and ready");
			apb(1'b0, mb(n, `CANI_MB_MDH), 32'h0);
			check(q, kept(n[0], d0, d1), "data high");
			apb(1'b0, mb(n, `CANI_MB_MDL), 32'h0);
			check(q, ~kept(n[0], d0, d1), "data low");
			apb(1'b0, mb(n, `CANI_MB_MSR), 32'h0);
			check(32'(q[24]), 32'h0, "lost cleared");
			apb(1'b1, mb(n, `CANI_MB_MCR), 32'h1 << `CANI_MCR_XFER);
			apb(1'b0, `CANI_SR_OFS, 32'h0);
			check(32'(q[n]), 32'h0, "ready released");
			check(32'(irq), 32'h0, "irq released");
		end
		$display("mailbox test done");

		e = 12'h001;
		e.frame_start = 1'b1;
		u_far.pulse(e);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[23]), 32'h1, "stamp source");
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[23]), 32'h0, "stamp cleared");
		apb(1'b1, `CANI_MODE_OFS, 32'h3);
		errs(3);
		apb(1'b0, `CANI_ECR_OFS, 32'h0);
		check(q, 32'h0, "autobaud frozen");
		check(32'(listen_only), 32'h1, "listen level");
		apb(1'b1, `CANI_MODE_OFS, 32'h1);
		errs(96);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[17]), 32'h0, "warn at 96");
		errs(1);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[17:16]), 32'h3, "warn above 96");
		errs(31);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[18:16]), 32'h4, "error passive");
		apb(1'b1, `CANI_MODE_OFS, 32'h5);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[21:20]), 32'h1, "sleep entered");
		check(32'(bus_active), 32'h0, "asleep off bus");
		apb(1'b1, `CANI_MODE_OFS, 32'h1);
		while (bus_active !== 1'b1)
			@(posedge pclk);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[21:20]), 32'h2, "wake after sync");
		e = 12'h001;
		e.tx_err = 1'b1;
		repeat (32) u_far.pulse(e);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[19:16]), 32'hC, "bus off");
		e = 12'h001;
		e.flags = 5'h1F;
		u_far.pulse(e);
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[28:24]), 32'h1F, "error flags set");
		u_far.pulse(e);
		apb(1'b1, `CANI_MODE_OFS, 32'h0);
		apb(1'b1, `CANI_MODE_OFS, 32'h1);
		apb(1'b0, `CANI_ECR_OFS, 32'h0);
		check(q, 32'h0, "reenable clears");
		apb(1'b0, `CANI_SR_OFS, 32'h0);
		check(32'(q[28:24]), 32'h0, "reenable flags");
		$display("status test done");
		report_and_stop();
	end
endmodule : tb
